// file: design/jesd204b_tx_link.sv
// Transmit link: sample packing, scrambler, sync/alignment sequencer,
// frame monitoring characters and 8b/10b encoder, one octet per clock.
// Assumes samples come from logic on aclk; sync and SYSREF are pins.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "jesd_tx_map.svh"
module jesd204b_tx_link
	import jesd_tx_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sample stream
	input wire logic [14:0] samp_i,
	input wire logic [14:0] samp_q,
	input wire logic threshold_flag_first,
	input wire logic threshold_flag_second,
	output logic samp_take,
	// Link pins
	input wire logic sync_req_n,
	input wire logic sysref,
	output logic [9:0] tx_symbol,
	output logic ser_power_en,
	output logic ser_clk_en,
	// Overrange pins and decimation setting
	output logic ovr_pin_first,
	output logic ovr_pin_second,
	output logic [4:0] decim_factor
);

	function automatic logic [5:0] code6(input logic [4:0] x);
		case (x)
			5'h00: code6 = 6'b100111;
			5'h01: code6 = 6'b011101;
			5'h02: code6 = 6'b101101;
			5'h03: code6 = 6'b110001;
			5'h04: code6 = 6'b110101;
			5'h05: code6 = 6'b101001;
			5'h06: code6 = 6'b011001;
			5'h07: code6 = 6'b111000;
			5'h08: code6 = 6'b111001;
			5'h09: code6 = 6'b100101;
			5'h0A: code6 = 6'b010101;
			5'h0B: code6 = 6'b110100;
			5'h0C: code6 = 6'b001101;
			5'h0D: code6 = 6'b101100;
			5'h0E: code6 = 6'b011100;
			5'h0F: code6 = 6'b010111;
			5'h10: code6 = 6'b011011;
			5'h11: code6 = 6'b100011;
			5'h12: code6 = 6'b010011;
			5'h13: code6 = 6'b110010;
			5'h14: code6 = 6'b001011;
			5'h15: code6 = 6'b101010;
			5'h16: code6 = 6'b011010;
			5'h17: code6 = 6'b111010;
			5'h18: code6 = 6'b110011;
			5'h19: code6 = 6'b100110;
			5'h1A: code6 = 6'b010110;
			5'h1B: code6 = 6'b110110;
			5'h1C: code6 = 6'b001110;
			5'h1D: code6 = 6'b101110;
			5'h1E: code6 = 6'b011110;
			default: code6 = 6'b101011;
		endcase
	endfunction : code6

	// Negative-disparity 4b codes; alt picks the A7 form of y=7
	function automatic logic [3:0] code4(input logic [2:0] y,
		input logic alt);
		case (y)
			3'h0: code4 = 4'b1011;
			3'h1: code4 = 4'b1001;
			3'h2: code4 = 4'b0101;
			3'h3: code4 = 4'b1100;
			3'h4: code4 = 4'b1101;
			3'h5: code4 = 4'b1010;
			3'h6: code4 = 4'b0110;
			default: code4 = alt ? 4'b0111 : 4'b1110;
		endcase
	endfunction : code4

	// K28.y tails for negative running disparity
	function automatic logic [3:0] k28tail(input logic [2:0] y);
		case (y)
			3'h0: k28tail = 4'b0100;
			3'h3: k28tail = 4'b0011;
			3'h4: k28tail = 4'b0010;
			3'h5: k28tail = 4'b1010;
			default: k28tail = 4'b1000;
		endcase
	endfunction : k28tail

	// Returns {next disparity, 10-bit symbol}; rd high means positive
	function automatic logic [10:0] enc(input logic [7:0] d,
		input logic is_k, input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic rm;
		logic alt;
		c6 = code6(d[4:0]);
		if (rd && (($countones(c6) != 3) || (c6 == 6'b111000)))
			c6 = ~c6;
		rm = rd ^ ($countones(c6) != 3);
		alt = rm ? (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)
			: (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14);
		c4 = code4(d[7:5], alt);
		if (rm && (($countones(c4) != 2) || (c4 == 4'b1100)))
			c4 = ~c4;
		enc = {rm ^ ($countones(c4) != 2), c6, c4};
		if (is_k) begin
			enc[9:0] = rd ? ~{`JT_K28_6B, k28tail(d[7:5])}
				: {`JT_K28_6B, k28tail(d[7:5])};
			enc[10] = rd ^ ($countones(enc[9:0]) != 5);
		end
	endfunction : enc

	// Bytewise self-synchronising scrambler; returns {state, octet}
	function automatic logic [22:0] scramble(input logic [7:0] d,
		input logic [14:0] s);
		logic [14:0] st;
		logic [7:0] o;
		st = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = d[i] ^ st[14] ^ st[13];
			st = {st[13:0], o[i]};
		end
		scramble = {st, o};
	endfunction : scramble

	link_state_t state_ff, nxt_state;
	logic [1:0] sync_sh_ff, sysref_sh_ff;
	logic sysref_d_ff;
	logic [1:0] ctrl_ff;
	logic [4:0] mode_ff, kminus_ff;
	logic [3:0] lanes_ff;
	logic bvalid_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [5:0] lmfc_ff;
	logic [1:0] ilas_mf_ff;
	logic iq_ff, rd_ff, prev_ok_ff;
	logic [15:0] word_ff;
	logic [7:0] prev_ff;
	logic [14:0] scr_ff;
	logic [9:0] sym_ff;
	logic ovr1_ff, ovr2_ff;
	logic [4:0] decim_ff;

	// Bus decode
	wire link_en = ctrl_ff[`JT_CTRL_EN];
	wire scr_en = ctrl_ff[`JT_CTRL_SCR];
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	wire wr_ctrl = wr_go && s_axi_awaddr == `JT_REG_CTRL;
	wire wr_cfg = wr_go && s_axi_awaddr == `JT_REG_CFG;
	wire wr_hit = wr_ctrl || wr_cfg || s_axi_awaddr == `JT_REG_STAT;
	wire rd_go = s_axi_arvalid && !rvalid_ff;
	wire rd_hit = s_axi_araddr == `JT_REG_CTRL
		|| s_axi_araddr == `JT_REG_CFG || s_axi_araddr == `JT_REG_STAT;
	wire [31:0] cfg_word = {12'h000, lanes_ff, 3'h0, kminus_ff,
		3'h0, mode_ff};
	wire [31:0] stat_word = {19'h00000, decim_ff, 4'h0, sync_sh_ff[1],
		state_ff};
	wire [31:0] rd_mux = (s_axi_araddr == `JT_REG_CTRL) ? {30'h0, ctrl_ff}
		: (s_axi_araddr == `JT_REG_CFG) ? cfg_word
		: (s_axi_araddr == `JT_REG_STAT) ? stat_word : 32'h00000000;

	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = rd_go;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `JT_RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= `JT_RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else begin
			bvalid_ff <= wr_go || (bvalid_ff && !s_axi_bready);
			if (wr_go)
				bresp_ff <= wr_hit ? `JT_RESP_OKAY : `JT_RESP_SLVERR;
			rvalid_ff <= rd_go || (rvalid_ff && !s_axi_rready);
			if (rd_go) begin
				rresp_ff <= rd_hit ? `JT_RESP_OKAY : `JT_RESP_SLVERR;
				rdata_ff <= rd_mux;
			end
		end
	end

	// Link parameters; software must drop the enable before editing them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= 2'h0;
			mode_ff <= `JT_RST_MODE;
			kminus_ff <= `JT_RST_KM1;
			lanes_ff <= `JT_RST_LANES;
		end else begin
			if (wr_ctrl && s_axi_wstrb[0])
				ctrl_ff <= s_axi_wdata[1:0];
			if (wr_cfg && s_axi_wstrb[0])
				mode_ff <= s_axi_wdata[`JT_CFG_MODE_LO +: 5];
			if (wr_cfg && s_axi_wstrb[1])
				kminus_ff <= s_axi_wdata[`JT_CFG_K_LO +: 5];
			if (wr_cfg && s_axi_wstrb[2])
				lanes_ff <= s_axi_wdata[`JT_CFG_LANE_LO +: 4];
		end
	end

	// Pin synchronisers; only the second stage feeds logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_sh_ff <= 2'h0;
			sysref_sh_ff <= 2'h0;
			sysref_d_ff <= 1'b0;
		end else begin
			sync_sh_ff <= {sync_sh_ff[0], sync_req_n};
			sysref_sh_ff <= {sysref_sh_ff[0], sysref};
			sysref_d_ff <= sysref_sh_ff[1];
		end
	end

	// Multiframe counter in octets: F is 2, so 2K octets per multiframe
	wire sync_ok = sync_sh_ff[1];
	wire sysref_rise = sysref_sh_ff[1] && !sysref_d_ff;
	wire [5:0] mf_last = {kminus_ff, 1'b1};
	wire mf_end = lmfc_ff == mf_last;
	wire frame_end = lmfc_ff[0];
	wire [5:0] nxt_lmfc = (!link_en || sysref_rise || mf_end) ? 6'h00
		: lmfc_ff + 6'h01;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: if (link_en) nxt_state = ST_CGS;
			ST_CGS: if (sync_ok) nxt_state = ST_WAIT;
			ST_WAIT: if (mf_end) nxt_state = ST_ILAS;
			ST_ILAS: begin
				if (mf_end && ilas_mf_ff == `JT_ILAS_LAST_MF)
					nxt_state = ST_DATA;
			end
			default: nxt_state = state_ff;
		endcase
		if (state_ff != ST_OFF && !sync_ok)
			nxt_state = ST_CGS;
		if (!link_en)
			nxt_state = ST_OFF;
	end

	// Sample word packing
	wire is_complex = mode_ff >= `JT_MODE_C4LO && mode_ff <= `JT_MODE_MAX;
	wire is_narrow = mode_ff == `JT_MODE_NARROW
		|| mode_ff < `JT_MODE_REAL2 || mode_ff > `JT_MODE_MAX;
	wire use_q = iq_ff && is_complex;
	wire [14:0] samp_sel = use_q ? samp_q : samp_i;
	wire flag_sel = iq_ff ? threshold_flag_second : threshold_flag_first;
	wire [15:0] word_w = is_narrow ? {samp_sel[14:3], 4'h0}
		: {samp_sel, flag_sel};
	wire [4:0] decim_w = (mode_ff >= `JT_MODE_C16LO && !(mode_ff
		> `JT_MODE_MAX)) ? 5'h10 : (mode_ff >= `JT_MODE_C8LO
		&& !(mode_ff > `JT_MODE_MAX)) ? 5'h08 : is_complex ? 5'h04
		: (mode_ff == `JT_MODE_REAL2) ? 5'h02 : 5'h01;

	assign samp_take = state_ff == ST_DATA && !frame_end;
	wire [7:0] data_oct = frame_end ? word_ff[7:0] : word_w[15:8];

	// Alignment sequence content
	wire [7:0] cfg_oct = (lmfc_ff == 6'h02) ? {4'h0, lanes_ff}
		: (lmfc_ff == 6'h03) ? `JT_F_M1
		: (lmfc_ff == 6'h04) ? {3'h0, kminus_ff}
		: (lmfc_ff == 6'h05) ? {3'h0, mode_ff} : {7'h00, scr_en};
	wire ilas_cfg = ilas_mf_ff == 2'h1 && lmfc_ff >= 6'h02
		&& lmfc_ff <= 6'h06 && !mf_end;
	wire ilas_q = ilas_mf_ff == 2'h1 && lmfc_ff == 6'h01 && !mf_end;
	wire ilas_k = lmfc_ff == 6'h00 || mf_end || ilas_q;
	wire [7:0] ilas_oct = mf_end ? {`JT_K28_3, 5'h1C}
		: (lmfc_ff == 6'h00) ? {`JT_K28_0, 5'h1C}
		: ilas_q ? {`JT_K28_4, 5'h1C}
		: ilas_cfg ? cfg_oct : {2'h0, lmfc_ff};

	// Data phase: scrambling and frame monitoring
	wire [22:0] scr_w = scramble(data_oct, scr_ff);
	wire [7:0] line_oct = scr_en ? scr_w[7:0] : data_oct;
	wire a_scr = scr_en && mf_end && line_oct == `JT_OCT_7C;
	wire f_scr = scr_en && frame_end && line_oct == `JT_OCT_FC;
	wire rep = !scr_en && frame_end && prev_ok_ff && data_oct == prev_ff;
	wire a_rep = rep && mf_end;
	wire f_rep = rep && !mf_end;
	wire dk = a_scr || f_scr || a_rep || f_rep;
	wire [7:0] dk_oct = (a_scr || a_rep) ? {`JT_K28_3, 5'h1C}
		: {`JT_K28_7, 5'h1C};

	wire enc_k = (state_ff == ST_DATA) ? dk
		: (state_ff == ST_ILAS) ? ilas_k : 1'b1;
	wire [7:0] enc_oct = (state_ff == ST_DATA) ? (dk ? dk_oct : line_oct)
		: (state_ff == ST_ILAS) ? ilas_oct : {`JT_K28_5, 5'h1C};
	wire [10:0] enc_w = enc(enc_oct, enc_k, rd_ff);
	wire in_data = state_ff == ST_DATA;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_OFF;
			lmfc_ff <= 6'h00;
			ilas_mf_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			lmfc_ff <= nxt_lmfc;
			if (state_ff != ST_ILAS)
				ilas_mf_ff <= 2'h0;
			else if (mf_end)
				ilas_mf_ff <= ilas_mf_ff + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_ff <= 16'h0000;
			iq_ff <= 1'b0;
			prev_ff <= 8'h00;
			prev_ok_ff <= 1'b0;
			scr_ff <= `JT_SCR_SEED;
		end else begin
			if (samp_take)
				word_ff <= word_w;
			iq_ff <= in_data && (samp_take ? !iq_ff : iq_ff);
			if (in_data && frame_end)
				prev_ff <= data_oct;
			prev_ok_ff <= in_data && (prev_ok_ff || frame_end);
			scr_ff <= (in_data && scr_en) ? scr_w[22:8] : `JT_SCR_SEED;
		end
	end

	// Serializer, overrange and decimation outputs; symbols and serializer enables are held quiet while the link is disabled, overrange and decimation are not
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sym_ff <= 10'h000;
			rd_ff <= 1'b0;
			ovr1_ff <= 1'b0;
			ovr2_ff <= 1'b0;
			decim_ff <= 5'h01;
		end else begin
			sym_ff <= (state_ff == ST_OFF) ? 10'h000 : enc_w[9:0];
			rd_ff <= (state_ff == ST_OFF) ? 1'b0 : enc_w[10];
			ovr1_ff <= mode_ff == `JT_MODE_NARROW && threshold_flag_first;
			ovr2_ff <= mode_ff == `JT_MODE_NARROW && threshold_flag_second;
			decim_ff <= decim_w;
		end
	end

	assign tx_symbol = sym_ff;
	assign ser_power_en = link_en;
	assign ser_clk_en = link_en;
	assign ovr_pin_first = ovr1_ff;
	assign ovr_pin_second = ovr2_ff;
	assign decim_factor = decim_ff;

endmodule : jesd204b_tx_link

// file: inc/jesd_tx_map.svh
// Constants of the transmit link: register map, fields, resets, codes.
// Assumes the package jesd_tx_pkg supplies the types that use them.
//
// Notes on behaviour
// - Complex words except in mode 12 hold 15-bit data high, first/second flag in I/Q bit 0.
// - Transport mode sets decimation: bypass, 9 by-2, 10-12, 13-14, 15-16.
// - Mode 12 sends 12-bit samples; flags go out on dedicated pins.
// - Up to 16 lanes at up to 12.8 Gbps; lane count is configurable; here one lane, count only sent in the alignment sequence.
// - A SYSREF pulse resets the local multiframe counter deterministically.
// - Mode plus frames per multiframe pick the octet/frame/lane mapping.
// - Octets are scrambled only while scramble enable is set.
// - The alignment sequence is never scrambled.
// - While the request is low, send K28.5 continuously.
// - After release, wait for own next multiframe edge before alignment.
// - Alignment sequence is four multiframes of fixed content.
// - Second alignment multiframe carries the link configuration.
// - Every octet is 8b/10b encoded before serialisation.
// - Unscrambled: frame end octet equal to previous one becomes K28.7.
// - Unscrambled: such a repeat at multiframe end becomes K28.3.
// - Scrambled: frame end octet 0xFC becomes K28.7.
// - Scrambled: multiframe end octet 0x7C becomes K28.3.
// - Clear link enable before changes; disabled link is reset, powered off.
`ifndef JESD_TX_MAP_SVH
`define JESD_TX_MAP_SVH
`define JT_REG_CTRL 8'h00
`define JT_REG_CFG 8'h04
`define JT_REG_STAT 8'h08
`define JT_CTRL_EN 0
`define JT_CTRL_SCR 1
`define JT_CFG_MODE_LO 0
`define JT_CFG_K_LO 8
`define JT_CFG_LANE_LO 16
`define JT_RST_MODE 5'h0A
`define JT_RST_KM1 5'h0F
`define JT_RST_LANES 4'hF
`define JT_MODE_REAL2 5'h09
`define JT_MODE_C4LO 5'h0A
`define JT_MODE_NARROW 5'h0C
`define JT_MODE_C8LO 5'h0D
`define JT_MODE_C16LO 5'h0F
`define JT_MODE_MAX 5'h10
`define JT_F_M1 8'h01
`define JT_ILAS_LAST_MF 2'h3
`define JT_OCT_FC 8'hFC
`define JT_OCT_7C 8'h7C
`define JT_K28_0 3'h0
`define JT_K28_3 3'h3
`define JT_K28_4 3'h4
`define JT_K28_5 3'h5
`define JT_K28_7 3'h7
`define JT_K28_6B 6'h0F
`define JT_SCR_SEED 15'h0000
`define JT_RESP_OKAY 2'h0
`define JT_RESP_SLVERR 2'h2
`endif

// file: inc/jesd_tx_pkg.sv
// Types shared by the transmit link design.
// Assumes jesd_tx_map.svh is compiled alongside for the constants.
package jesd_tx_pkg;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_CGS = 3'b001,
		ST_WAIT = 3'b010,
		ST_ILAS = 3'b011,
		ST_DATA = 3'b100
	} link_state_t;
endpackage : jesd_tx_pkg

// file: verification/jesd204b_tx_link_props.sv
// Checker for the transmit link: bus answers, comma stream, quiet link.
// Assumes it is bound to jesd204b_tx_link and sees its ports only.
`timescale 1ns/100ps
module jesd204b_tx_link_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Link side
	input wire logic sync_req_n,
	input wire logic samp_take,
	input wire logic [9:0] tx_symbol,
	input wire logic ser_power_en,
	input wire logic ser_clk_en,
	input wire logic ovr_pin_first,
	input wire logic ovr_pin_second,
	input wire logic [4:0] decim_factor
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire comma = tx_symbol == 10'h0FA || tx_symbol == 10'h305;
	// Six cycles cover the pin synchroniser, the state and the symbol stage
	sequence s_request_held;
		(ser_power_en && !sync_req_n) [*6];
	endsequence
	sequence s_link_off;
		!ser_power_en [*3];
	endsequence
	a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid
		&& !s_axi_bvalid |=> s_axi_bvalid) else $error("write unanswered");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
		|=> s_axi_rvalid) else $error("read unanswered");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_awready_term: assert property (s_axi_awready
		== (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
		else $error("awready wrong");
	a_comma_stream: assert property (
		s_request_held |-> comma) else $error("comma missing");
	a_quiet_off: assert property (
		s_link_off |-> tx_symbol == 10'h000) else $error("symbols while off");
	a_serdes_gated: assert property (
		ser_clk_en == ser_power_en) else $error("serializer clock mismatch");
	a_decim_legal: assert property (
		decim_factor inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
		else $error("illegal decimation");
	a_flags_narrow: assert property (
		ovr_pin_first || ovr_pin_second |-> decim_factor == 5'h04)
		else $error("overrange pin outside mode");
	a_take_spacing: assert property (
		samp_take |=> !samp_take) else $error("word taken twice");
	// Alignment characters may only replace the last octet of a frame
	wire align_char = tx_symbol == 10'h0F8 || tx_symbol == 10'h307
		|| tx_symbol == 10'h0F3 || tx_symbol == 10'h30C;
	a_align_place: assert property (
		align_char |-> !$past(samp_take)) else $error("misplaced align char");
endmodule : jesd204b_tx_link_props
bind jesd204b_tx_link jesd204b_tx_link_props u_props (.*);

// file: verification/jesd_rx_model.sv
// Receiver at the far end of the link: the sync request handshake.
// Assumes one lane, symbols sampled on the device clock.
`timescale 1ns/100ps
module jesd_rx_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	input wire logic [9:0] tx_symbol,
	input wire logic start,
	output logic sync_req_n
);
	logic [2:0] comma_ff, mf_ff;
	logic done_ff, cgs_ff;
	wire comma = tx_symbol == 10'h0FA || tx_symbol == 10'h305;
	// Own multiframe is eight octets, matching the bench's K of four;
	// its phase is free, so the device must still find its own edge
	always_ff @(posedge aclk) begin
		if (!aresetn || !start) begin
			sync_req_n <= 1'b1;
			comma_ff <= 3'h0;
			mf_ff <= 3'h0;
			cgs_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			mf_ff <= mf_ff + 3'h1;
			comma_ff <= comma ? comma_ff + 3'h1 : 3'h0;
			cgs_ff <= cgs_ff || (comma && comma_ff == 3'h3);
			if (done_ff || (cgs_ff && mf_ff == 3'h7)) begin
				sync_req_n <= 1'b1;
				done_ff <= 1'b1;
			end else begin
				sync_req_n <= 1'b0;
			end
		end
	end
endmodule : jesd_rx_model

// file: verification/tb.sv
// Bench: registers, decimation modes, link bring-up twice, disable.
// Assumes the receiver model drives the sync request pin.
`timescale 1ns/100ps
module tb
	import jesd_tx_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, sysref = 1'b0, start = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clr = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [14:0] samp_i = 15'h1234, samp_q = 15'h1234;
	logic threshold_flag_first = 1'b1, threshold_flag_second = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, samp_take, sync_req_n, ser_power_en, ser_clk_en;
	logic ovr_pin_first, ovr_pin_second;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [9:0] tx_symbol;
	logic [4:0] decim_factor;
	int fail_count = 0, total_checks = 0;
	int n_k0, n_k3, n_k4, n_k5, n_k7, n_take;

	jesd204b_tx_link DUT (.*);
	jesd_rx_model u_rx (.aclk, .aresetn, .tx_symbol, .start, .sync_req_n);

	always #20 aclk = ~aclk;

	function automatic int is_k(input logic [9:0] neg);
		return int'(tx_symbol === neg || tx_symbol === ~neg);
	endfunction : is_k

	always @(posedge aclk) begin
		n_k0 <= clr ? 0 : n_k0 + is_k(10'h0F4);
		n_k3 <= clr ? 0 : n_k3 + is_k(10'h0F3);
		n_k4 <= clr ? 0 : n_k4 + is_k(10'h0F2);
		n_k5 <= clr ? 0 : n_k5 + is_k(10'h0FA);
		n_k7 <= clr ? 0 : n_k7 + is_k(10'h0F8);
		n_take <= clr ? 0 : n_take + int'(samp_take === 1'b1);
	end

	task automatic chk(input logic [31:0] got, exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk);
		while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(8'h04, d, r);
		chk(d, 32'h000F0F0A, "cfg reset");
		rd(8'h00, d, r);
		chk(d, 32'h0, "ctrl reset");
		rd(8'h08, d, r);
		chk(d[2:0], 3'h0, "stat reset");
		rd(8'h0C, d, r);
		chk({d[29:0], r}, 32'h2, "unmapped read");
		wr(8'h0C, 32'h3, r);
		chk(r, 2'h2, "unmapped write");
		wr(8'h08, 32'h0, r);
		chk(r, 2'h0, "stat write");
		$display("test regs done");
	endtask : t_regs

	task automatic t_modes();
		logic [1:0] r;
		logic [4:0] m;
		for (int i = 8; i <= 16; i++) begin
			m = (i == 8) ? 5'h00 : 5'(i);
			wr(8'h04, {24'h000F03, 3'h0, m}, r);
			repeat (2) @(posedge aclk);
			chk(decim_factor, i < 9 ? 1 : i == 9 ? 2 : i < 13 ? 4 : i < 15 ? 8
				: 16, "decimation");
			chk({ovr_pin_first, ovr_pin_second}, {2{i == 12}}, "ovr pins");
		end
		$display("test modes done");
	endtask : t_modes

	task automatic t_link(input logic [31:0] ctrl);
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h04, 32'h000F030A, r);
		wr(8'h00, ctrl, r);
		sysref <= 1'b1;
		clr <= 1'b1;
		@(posedge aclk);
		sysref <= 1'b0;
		clr <= 1'b0;
		start <= 1'b1;
		d = 32'h0;
		for (int i = 0; i < 80 && d[2:0] !== 3'(ST_DATA); i++)
			rd(8'h08, d, r);
		repeat (4) @(posedge aclk);
		chk(d[2:0], 3'(ST_DATA), "link up");
		chk(n_k5 >= 4, 1, "commas");
		chk(n_k0, 4, "alignment multiframes");
		chk(n_k4, 1, "config multiframe");
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (41) @(posedge aclk);
		chk(n_take, 20, "word rate");
		if (ctrl[1]) chk(n_k7 + n_k3 < 20, 1, "scrambled");
		else begin
			chk(n_k7, 15, "frame repeat chars");
			chk(n_k3, 5, "multiframe repeat chars");
		end
		$display("test link done");
	endtask : t_link

	task automatic t_off();
		logic [31:0] d;
		logic [1:0] r;
		start <= 1'b0;
		wr(8'h00, 32'h0, r);
		repeat (4) @(posedge aclk);
		chk({ser_power_en, ser_clk_en, tx_symbol}, 12'h0, "link off");
		rd(8'h08, d, r);
		chk(d[2:0], 3'h0, "state off");
		$display("test off done");
	endtask : t_off

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		$display("unexpected at %0t: timeout", $time);
		end_of_test();
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_modes();
		t_link(32'h1);
		t_off();
		t_link(32'h3);
		t_off();
		end_of_test();
	end
endmodule : tb
